// >>> hw/mpd_regs.svh
// Offsets, field positions, special codes and timing counts of the decoder
`ifndef MPD_REGS_SVH
`define MPD_REGS_SVH
// Notes on behaviour
// - Parameter write replaces RAM, node address excepted
// - Node address: four programmed plus three hardwired
// - Stall code zero disables, else 0.6-9.6 V
// - Three-bit selector picks paired undervoltage levels
// - Run code maps 59-800 mA, boost 81-1100
// - One bit chooses rotation direction
// - Lost link or error overflow drives safe target
// - Pattern 100 0000 00xx skips automatic safe moves
// - Safe target is 11 MSBs, two loaded zero
// - Hold code table as run, 1111 zero
// - At stop lower current from run to hold
// - Zero hold: minimum code first, then bridge off
// - Step field selects half to sixteenth stepping
// - Bank bit picks bytes 5/6 or 8/9; acceleration code and shaft bit always load from byte 5
// - Byte read with bank set returns 8/9
// - Speed code maps 99-973 full steps/s
// - Ramp code maps 49-40047 full steps/s2
// - Sleep permit set: bus timeout enters sleep
// - Permit clear: timeout stops with hold current, but enters sleep in standby/shutdown
// - Sleep command sleeps if permitted, else stops
// - New non-volatile bits act after power cycle
`define MPD_OFS_MOTOR   8'h00
`define MPD_OFS_CONFIG  8'h04
`define MPD_OFS_ADDR    8'h08
`define MPD_OFS_NVIDX   8'h0C
`define MPD_OFS_NVDATA  8'h10
`define MPD_OFS_STATUS  8'h14
`define MPD_IRUN_LSB    0
`define MPD_IHOLD_LSB   4
`define MPD_VMIN_LSB    8
`define MPD_VMAX_LSB    12
`define MPD_ACC_LSB     16
`define MPD_SHAFT_BIT   20
`define MPD_SAFE_LSB    21
`define MPD_STALL_LSB   0
`define MPD_UV_LSB      4
`define MPD_STEP_LSB    8
`define MPD_SLEEP_BIT   12
`define MPD_LOST_BIT    13
`define MPD_NV_BANK_B   4'h0
`define MPD_NV_BANK_BIT 7
`define MPD_NV_ADDR_B   4'h2
`define MPD_NV_CUR_B    4'h3
`define MPD_NV_SPD_B    4'h4
`define MPD_NV_SPA_B    4'h5
`define MPD_NV_SPB_B    4'h6
`define MPD_NV_CFG_B    4'h7
`define MPD_NV_ALTA_B   4'h8
`define MPD_NV_ALTB_B   4'h9
`define MPD_SAFE_OFF    9'h100
`define MPD_IHOLD_ZERO  4'hF
`define MPD_CLK_MHZ     25
`define MPD_DROP_NS     2000
`define MPD_DROP_CYC    ((`MPD_DROP_NS * `MPD_CLK_MHZ + 999) / 1000)
`endif

// >>> hw/mpd_pkg.sv
// Types shared by the parameter decoder modules
package mpd_pkg;
  typedef enum logic [1:0] {LD_LOAD = 2'h1, LD_READY = 2'h2} mpd_load_t;
  typedef enum logic [3:0] {
    HS_RUN  = 4'h1,
    HS_HOLD = 4'h2,
    HS_MIN  = 4'h4,
    HS_OFF  = 4'h8
  } mpd_hold_t;
  typedef enum logic [1:0] {
    GRP_A = 2'h0,
    GRP_B = 2'h1,
    GRP_C = 2'h2,
    GRP_D = 2'h3
  } mpd_group_t;
endpackage

// >>> hw/mpd_ahb_slave.sv
// AHB-Lite slave front end for the parameter registers
`timescale 1ns/1ps
`include "mpd_regs.svh"
module mpd_ahb_slave (
  input  wire logic        hclk,      // Bus clock
  input  wire logic        hresetn,   // Async reset, active low
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write when high
  input  wire logic [2:0]  hsize,     // Word only
  input  wire logic [31:0] hwdata,    // Write data
  input  wire logic        hready,    // Bus ready
  output logic             hreadyout, // Always ready
  output logic             hresp,     // Always OKAY
  output logic [31:0]      hrdata,    // Read data
  input  wire logic [31:0] rd_data,   // Register read value
  output logic [7:0]       rd_addr,   // Read address, address phase
  output logic             wr_stb,    // Write strobe, data phase
  output logic [7:0]       wr_addr,   // Write address
  output logic [31:0]      wr_data    // Write data
);
  logic take;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;

  // Reads sampled at the address phase so no wait state is needed
  assign take = hsel & hready & htrans[1];
  assign rd_addr = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign wr_stb = wr_pend_reg;
  assign wr_addr = wr_addr_reg;
  assign wr_data = hwdata;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= take & hwrite;
      if (take)
        wr_addr_reg <= haddr[7:0];
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata_reg <= 32'h0;
    else if (take && !hwrite)
      hrdata_reg <= rd_data;
endmodule

// >>> hw/mpd_hold_seq.sv
// Standstill current sequencer: run, hold, minimum, bridge off
`timescale 1ns/1ps
`include "mpd_regs.svh"
module mpd_hold_seq #(
  parameter int DROP_CYC = `MPD_DROP_CYC
) (
  input  wire logic        hclk,              // Clock
  input  wire logic        hresetn,           // Async reset, active low
  input  wire logic        motor_stopped,     // Motion finished
  input  wire logic        ihold_zero,        // Hold code means zero
  output mpd_pkg::mpd_hold_t state,           // Current phase
  output logic             pwm_enable,        // Regulator on
  output logic             bridge_low_ground  // Low side grounded
);
  localparam int CW = $clog2(DROP_CYC + 1);
  mpd_pkg::mpd_hold_t st_reg;
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      st_reg <= mpd_pkg::HS_RUN;
    else
      case (st_reg)
        mpd_pkg::HS_RUN:
          if (motor_stopped)
            st_reg <= ihold_zero ? mpd_pkg::HS_MIN
                                 : mpd_pkg::HS_HOLD;
        mpd_pkg::HS_HOLD:
          if (!motor_stopped)
            st_reg <= mpd_pkg::HS_RUN;
          else if (ihold_zero)
            st_reg <= mpd_pkg::HS_MIN;
        mpd_pkg::HS_MIN:
          if (!motor_stopped)
            st_reg <= mpd_pkg::HS_RUN;
          else if (cnt_reg == CW'(DROP_CYC - 1))
            st_reg <= mpd_pkg::HS_OFF;
        mpd_pkg::HS_OFF:
          if (!motor_stopped)
            st_reg <= mpd_pkg::HS_RUN;
          else if (!ihold_zero)
            st_reg <= mpd_pkg::HS_HOLD;
        default:
          st_reg <= mpd_pkg::HS_RUN;
      endcase

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cnt_reg <= '0;
    else if (st_reg != mpd_pkg::HS_MIN)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + CW'(1);

  assign state = st_reg;
  assign pwm_enable = (st_reg != mpd_pkg::HS_OFF);
  assign bridge_low_ground = (st_reg == mpd_pkg::HS_OFF);
endmodule

// >>> hw/mpd_param_decode.sv
// Motion parameter shadow registers, decoders and safe-target control
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "mpd_regs.svh"
module mpd_param_decode #(
  parameter int DROP_CYC = `MPD_DROP_CYC
) (
  input  wire logic        hclk,                 // Clock, 25 MHz
  input  wire logic        hresetn,              // Async reset, low
  input  wire logic        hsel,                 // AHB select
  input  wire logic [31:0] haddr,                // AHB address
  input  wire logic [1:0]  htrans,               // AHB transfer type
  input  wire logic        hwrite,               // AHB write
  input  wire logic [2:0]  hsize,                // AHB size
  input  wire logic [31:0] hwdata,               // AHB write data
  input  wire logic        hready,               // AHB ready in
  output logic             hreadyout,            // AHB ready out
  output logic             hresp,                // AHB response
  output logic [31:0]      hrdata,               // AHB read data
  input  wire logic [79:0] nv_image,             // Bytes 0..9
  input  wire logic [2:0]  hardwired_addr_bits,  // Pin address bits
  input  wire logic        motor_stopped,        // Motion finished
  input  wire logic        boost_en,             // Boost current active
  input  wire logic        bus_timeout,          // Link lost pulse
  input  wire logic        bus_err_overflow,     // Error count overflow
  input  wire logic        sleep_cmd,            // Bus sleep command
  input  wire logic        standby_or_shutdown,  // In standby/shutdown
  input  wire logic        goto_safe_target_cmd, // Explicit safe move
  output logic             params_ready,         // Shadow loaded
  output logic [6:0]       node_addr,            // Bus node address
  output logic             stall_detect_en,      // Motion detect on
  output logic [13:0]      stall_threshold_mv,   // Back-EMF level
  output logic [13:0]      undervolt_warn_level, // Warning level, mV
  output logic [13:0]      undervolt_recover_level, // Recovery, mV
  output logic [10:0]      coil_current_ma,      // Coil amplitude
  output logic             pwm_enable,           // Regulator on
  output logic             bridge_low_ground,    // Low side grounded
  output logic             shaft_dir,            // 1 counter-clockwise
  output logic [4:0]       microstep_div,        // 2, 4, 8 or 16
  output logic [9:0]       vmax_fsps,            // Max full steps/s
  output mpd_pkg::mpd_group_t speed_group,       // Speed group
  output logic [3:0]       vmin_code,            // Min speed factor
  output logic [15:0]      accel_fsps2,          // Ramp rate
  output logic             accel_speed_limited,  // Ramp limits speed
  output logic [15:0]      safe_target,          // Safe position
  output logic             safe_move_req,        // Go to safe, pulse
  output logic             dual_safe_allowed,    // Dual cmd may go safe
  output logic             enter_sleep,          // Sleep, pulse
  output logic             enter_stop            // Stop with hold, pulse
);
  localparam logic [10:0] RUN_MA [16] = '{
    11'h03B, 11'h047, 11'h054, 11'h064, 11'h077, 11'h08D, 11'h0A8, 11'h0C8,
    11'h0EE, 11'h11B, 11'h150, 11'h190, 11'h1DC, 11'h236, 11'h2A1, 11'h320};
  localparam logic [10:0] BST_MA [16] = '{
    11'h051, 11'h062, 11'h074, 11'h08A, 11'h0A4, 11'h0C2, 11'h0E7, 11'h113,
    11'h147, 11'h185, 11'h1CE, 11'h226, 11'h28F, 11'h30A, 11'h39D, 11'h44C};
  localparam logic [13:0] STALL_MV [16] = '{
    14'h0000, 14'h0258, 14'h0514, 14'h076C, 14'h0A28, 14'h0C80, 14'h0F3C,
    14'h1194, 14'h13EC, 14'h16A8, 14'h1900, 14'h1BBC, 14'h1E14, 14'h206C,
    14'h2328, 14'h2580};
  localparam logic [13:0] UVW_MV [8] = '{14'h170C, 14'h189C, 14'h1A2C,
    14'h1BBC, 14'h1D4C, 14'h1EDC, 14'h206C, 14'h21FC};
  localparam logic [13:0] UVR_MV [8] = '{14'h19DC, 14'h1B9E, 14'h1D60,
    14'h1F22, 14'h20DA, 14'h229C, 14'h245E, 14'h2620};
  localparam logic [9:0] VMAX_FS [16] = '{
    10'h063, 10'h088, 10'h0A7, 10'h0C5, 10'h0D5, 10'h0E4, 10'h0F3, 10'h111,
    10'h12F, 10'h14E, 10'h16C, 10'h18B, 10'h1C8, 10'h222, 10'h2D9, 10'h3CD};
  localparam logic [15:0] ACC_FS [16] = '{
    16'h0031, 16'h00DA, 16'h03EC, 16'h0E19, 16'h1854, 16'h2290, 16'h2C91,
    16'h3692, 16'h4093, 16'h4A94, 16'h557E, 16'h5F7F, 16'h6980, 16'h7382,
    16'h886D, 16'h9C6F};
  localparam logic [15:0] ACC_LIM = 16'hFE03;

  mpd_pkg::mpd_load_t ld_reg;
  mpd_pkg::mpd_hold_t hold_st;
  logic [3:0]  pa_reg, irun_reg, ihold_reg, vmin_reg, vmax_reg, acc_reg;
  logic [3:0]  stall_reg, nvidx_reg;
  logic [2:0]  hw_reg, uv_reg;
  logic [1:0]  step_reg;
  logic [10:0] safe_reg;
  logic        shaft_reg, sleep_reg, lost_reg, ready;
  logic [7:0]  rd_addr, wr_addr;
  logic [31:0] rd_data, wr_data;
  logic        wr_stb, safe_off, run_phase;
  logic [3:0]  cur_code;
  logic [7:0]  nv_a, nv_b;

  // Byte read with the alternate bank mapped over bytes 5 and 6
  function automatic logic [7:0] nv_byte(input logic [79:0] img,
                                         input logic [3:0] idx);
    logic       bank;
    logic [3:0] src;
    bank = img[8 * `MPD_NV_BANK_B + `MPD_NV_BANK_BIT];
    src = idx;
    if (bank && idx == `MPD_NV_SPA_B)
      src = `MPD_NV_ALTA_B;
    else if (bank && idx == `MPD_NV_SPB_B)
      src = `MPD_NV_ALTB_B;
    nv_byte = (idx > `MPD_NV_ALTB_B) ? 8'h00 : img[8 * src +: 8];
  endfunction

  mpd_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_data   (rd_data),
    .rd_addr   (rd_addr),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

  mpd_hold_seq #(.DROP_CYC(DROP_CYC)) u_hold (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .motor_stopped     (motor_stopped),
    .ihold_zero        (ihold_reg == `MPD_IHOLD_ZERO),
    .state             (hold_st),
    .pwm_enable        (pwm_enable),
    .bridge_low_ground (bridge_low_ground)
  );

  assign ready = (ld_reg == mpd_pkg::LD_READY);
  assign nv_a = nv_byte(nv_image, `MPD_NV_SPA_B);
  assign nv_b = nv_byte(nv_image, `MPD_NV_SPB_B);

  // Image is read once after reset; later programming waits a power cycle
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ld_reg <= mpd_pkg::LD_LOAD;
    else
      case (ld_reg)
        mpd_pkg::LD_LOAD:  ld_reg <= mpd_pkg::LD_READY;
        mpd_pkg::LD_READY: ld_reg <= mpd_pkg::LD_READY;
        default:           ld_reg <= mpd_pkg::LD_LOAD;
      endcase

  // Node address bits are loaded only, never written by software
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pa_reg <= 4'h0;
      hw_reg <= 3'h0;
    end
    else if (!ready)
    begin
      pa_reg <= nv_image[8 * `MPD_NV_ADDR_B +: 4];
      hw_reg <= hardwired_addr_bits;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      {irun_reg, ihold_reg, vmin_reg, vmax_reg, acc_reg} <= 20'h0;
      shaft_reg <= 1'b0;
      safe_reg <= 11'h000;
    end
    else if (!ready)
    begin
      {irun_reg, ihold_reg} <= nv_image[8 * `MPD_NV_CUR_B +: 8];
      {vmax_reg, vmin_reg} <= nv_image[8 * `MPD_NV_SPD_B +: 8];
      acc_reg <= nv_image[8 * `MPD_NV_SPA_B +: 4];
      shaft_reg <= nv_image[8 * `MPD_NV_SPA_B + 4];
      safe_reg <= {nv_a[7:5], nv_b[7:2], 2'h0};
    end
    else if (wr_stb && wr_addr == `MPD_OFS_MOTOR)
    begin
      irun_reg <= wr_data[`MPD_IRUN_LSB +: 4];
      ihold_reg <= wr_data[`MPD_IHOLD_LSB +: 4];
      vmin_reg <= wr_data[`MPD_VMIN_LSB +: 4];
      vmax_reg <= wr_data[`MPD_VMAX_LSB +: 4];
      acc_reg <= wr_data[`MPD_ACC_LSB +: 4];
      shaft_reg <= wr_data[`MPD_SHAFT_BIT];
      safe_reg <= wr_data[`MPD_SAFE_LSB +: 11];
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      stall_reg <= 4'h0;
      uv_reg <= 3'h0;
      step_reg <= 2'h0;
      sleep_reg <= 1'b0;
      lost_reg <= 1'b0;
    end
    else if (!ready)
    begin
      stall_reg <= nv_image[8 * `MPD_NV_ADDR_B + 4 +: 4];
      {uv_reg, step_reg} <= nv_image[8 * `MPD_NV_CFG_B + 2 +: 5];
      {lost_reg, sleep_reg} <= nv_b[1:0];
    end
    else if (wr_stb && wr_addr == `MPD_OFS_CONFIG)
    begin
      stall_reg <= wr_data[`MPD_STALL_LSB +: 4];
      uv_reg <= wr_data[`MPD_UV_LSB +: 3];
      step_reg <= wr_data[`MPD_STEP_LSB +: 2];
      sleep_reg <= wr_data[`MPD_SLEEP_BIT];
      lost_reg <= wr_data[`MPD_LOST_BIT];
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      nvidx_reg <= 4'h0;
    else if (wr_stb && wr_addr == `MPD_OFS_NVIDX)
      nvidx_reg <= wr_data[3:0];

  always_comb
  begin
    rd_data = 32'h0;
    if (rd_addr == `MPD_OFS_MOTOR)
      rd_data = {safe_reg, shaft_reg, acc_reg, vmax_reg, vmin_reg,
                 ihold_reg, irun_reg};
    else if (rd_addr == `MPD_OFS_CONFIG)
      rd_data = {18'h0, lost_reg, sleep_reg, 2'h0, step_reg, 1'b0, uv_reg,
                 stall_reg};
    else if (rd_addr == `MPD_OFS_ADDR)
      rd_data = {23'h0, ready, 1'b0, node_addr};
    else if (rd_addr == `MPD_OFS_NVIDX)
      rd_data = {28'h0, nvidx_reg};
    else if (rd_addr == `MPD_OFS_NVDATA)
      rd_data = {24'h0, nv_byte(nv_image, nvidx_reg)};
    else if (rd_addr == `MPD_OFS_STATUS)
      rd_data = {17'h0, hold_st, coil_current_ma};
  end

  // Current code by standstill phase
  assign run_phase = (hold_st == mpd_pkg::HS_RUN);
  always_comb
  begin
    cur_code = irun_reg;
    if (hold_st == mpd_pkg::HS_HOLD)
      cur_code = (ihold_reg == `MPD_IHOLD_ZERO) ? 4'h0 : ihold_reg;
    else if (hold_st == mpd_pkg::HS_MIN)
      cur_code = 4'h0;
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      coil_current_ma <= 11'h000;
    else if (hold_st == mpd_pkg::HS_OFF)
      coil_current_ma <= 11'h000;
    else
      coil_current_ma <= boost_en ? BST_MA[cur_code] : RUN_MA[cur_code];

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      node_addr <= 7'h00;
      stall_detect_en <= 1'b0;
      stall_threshold_mv <= 14'h0000;
      undervolt_warn_level <= 14'h0000;
      undervolt_recover_level <= 14'h0000;
      shaft_dir <= 1'b0;
      microstep_div <= 5'h02;
    end
    else
    begin
      node_addr <= {hw_reg, pa_reg};
      stall_detect_en <= (stall_reg != 4'h0);
      stall_threshold_mv <= STALL_MV[stall_reg];
      undervolt_warn_level <= UVW_MV[uv_reg];
      undervolt_recover_level <= UVR_MV[uv_reg];
      shaft_dir <= shaft_reg;
      microstep_div <= 5'(5'h02 << step_reg);
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      vmax_fsps <= 10'h000;
      speed_group <= mpd_pkg::GRP_A;
      vmin_code <= 4'h0;
      accel_fsps2 <= 16'h0000;
      accel_speed_limited <= 1'b0;
    end
    else
    begin
      vmax_fsps <= VMAX_FS[vmax_reg];
      if (vmax_reg == 4'h0)
        speed_group <= mpd_pkg::GRP_A;
      else if (vmax_reg < 4'h7)
        speed_group <= mpd_pkg::GRP_B;
      else if (vmax_reg < 4'hD)
        speed_group <= mpd_pkg::GRP_C;
      else
        speed_group <= mpd_pkg::GRP_D;
      vmin_code <= vmin_reg;
      accel_fsps2 <= ACC_FS[acc_reg];
      accel_speed_limited <= ACC_LIM[acc_reg];
    end

  // Safe target handling; motion requests wait for the shadow load
  assign safe_off = (safe_reg[10:2] == `MPD_SAFE_OFF);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      safe_target <= 16'h0000;
      safe_move_req <= 1'b0;
      dual_safe_allowed <= 1'b0;
    end
    else
    begin
      safe_target <= {safe_reg, 5'h00};
      safe_move_req <= ready & (goto_safe_target_cmd |
        (!safe_off & ((bus_timeout & lost_reg) | bus_err_overflow)));
      dual_safe_allowed <= ready & !safe_off;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      enter_sleep <= 1'b0;
      enter_stop <= 1'b0;
    end
    else
    begin
      enter_sleep <= ready & (((bus_timeout | sleep_cmd) & sleep_reg)
        | (bus_timeout & standby_or_shutdown));
      enter_stop <= ready & !sleep_reg & (sleep_cmd
        | (bus_timeout & !standby_or_shutdown));
    end

  assign params_ready = ready;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  node_addr_fixed_a: assert property (
    ready && $past(ready, 2) |-> $stable(node_addr))
    else $error("node address changed after load");
  addr_forming_a: assert property (
    $rose(ready) |=> node_addr == {$past(hardwired_addr_bits, 2),
                                   $past(nv_image[19:16], 2)})
    else $error("node address not formed from load values");
  stall_disable_a: assert property (
    ##1 stall_detect_en == ($past(stall_reg) != 4'h0))
    else $error("stall enable does not follow code");
  uv_pair_a: assert property (
    ready ##1 ready |-> undervolt_recover_level > undervolt_warn_level)
    else $error("recovery level not above warning level");
  run_current_a: assert property (
    run_phase && !boost_en |=> coil_current_ma >= 11'h03B
                                && coil_current_ma <= 11'h320)
    else $error("run current outside table range");
  zero_hold_seq_a: assert property (
    $rose(bridge_low_ground) |-> $past(hold_st) == mpd_pkg::HS_MIN
                                 && !pwm_enable)
    else $error("bridge grounded without minimum current phase");
  safe_skip_a: assert property (
    ready && safe_off && !goto_safe_target_cmd |=> !safe_move_req)
    else $error("automatic safe move while disabled");
  goto_safe_a: assert property (
    ready && goto_safe_target_cmd |=> safe_move_req)
    else $error("explicit safe move not requested");
  safe_low_a: assert property (
    $rose(ready) |-> safe_reg[1:0] == 2'h0)
    else $error("safe target low bits not zero after load");
  sleep_timeout_a: assert property (
    ready && bus_timeout && sleep_reg |=> enter_sleep && !enter_stop)
    else $error("timeout with permit did not sleep");
  sleep_cmd_stop_a: assert property (
    ready && sleep_cmd && !sleep_reg && !bus_timeout |=> enter_stop
                                                         && !enter_sleep)
    else $error("sleep command without permit did not stop");
  cover_zero_hold_c: cover property (hold_st == mpd_pkg::HS_OFF);
  cover_bank_c: cover property (ready && nv_image[7] && safe_move_req);
  cover_sleep_c: cover property (enter_sleep ##[1:40] enter_stop);
endmodule

// >>> tb/mpd_lin_master.sv
// Far-side master model: registers bench requests into event pulses one cycle later
`timescale 1ns/1ps
module mpd_lin_master (
  input  wire logic       hclk,   // Clock
  input  wire logic [3:0] ev_req, // Timeout, sleep, goto safe, error
  output logic      [3:0] ev      // Registered event pulses
);
  // Registered so events never change in the design's sampling step
  always_ff @(posedge hclk)
    ev <= ev_req;
endmodule

// >>> tb/motion_param_decode_tb.sv
// Self-checking bench for the motion parameter decoder
`timescale 1ns/1ps
module motion_param_decode_tb;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic        stopped = 1'h0, boost = 1'h0, rdy, pwm, gnd, mv, slp, stp;
  logic        sby = 1'h0, sten, prdy, shft, dual;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, grp;
  logic [3:0]  ev_req = 4'h0, ev;
  logic [6:0]  node;
  logic [13:0] thr, uvw;
  logic [10:0] coil;
  logic [4:0]  div;
  logic [9:0]  vmax;
  logic [15:0] safe, acc;
  logic [79:0] nv = 80'h05_E0_08_00_00_00_F7_35_00_80;
  int          fail_count = 0, comparisons = 0, cyc = 0;
  always #20 hclk = ~hclk;
  mpd_lin_master LM (.hclk(hclk), .ev_req(ev_req), .ev(ev));
  mpd_param_decode #(.DROP_CYC(2)) DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy),
    .hresp(), .hrdata(hrdata), .hardwired_addr_bits(3'h6),
    .nv_image(nv), .motor_stopped(stopped),
    .boost_en(boost), .bus_timeout(ev[0]), .sleep_cmd(ev[1]),
    .goto_safe_target_cmd(ev[2]), .bus_err_overflow(ev[3]),
    .standby_or_shutdown(sby), .params_ready(prdy), .node_addr(node),
    .stall_detect_en(sten), .stall_threshold_mv(thr),
    .undervolt_warn_level(uvw),
    .undervolt_recover_level(), .coil_current_ma(coil), .pwm_enable(pwm),
    .bridge_low_ground(gnd), .shaft_dir(shft), .microstep_div(div),
    .vmax_fsps(vmax), .speed_group(grp), .vmin_code(), .accel_fsps2(acc),
    .accel_speed_limited(), .safe_target(safe), .safe_move_req(mv),
    .dual_safe_allowed(dual), .enter_sleep(slp), .enter_stop(stp));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, hwrite, htrans, haddr} <= {1'h1, w, 2'h2, 24'h0, a};
    do @(posedge hclk); while (rdy !== 1'h1);
    {hsel, hwrite, htrans, hwdata} <= {1'h0, 1'h0, 2'h0, d};
    do @(posedge hclk); while (rdy !== 1'h1);
    rd = hrdata;
  endtask
  task ev_chk(input logic [3:0] r, input logic [2:0] e);
    logic [2:0] seen;
    seen = 3'h0;
    @(posedge hclk);
    ev_req <= r;
    @(posedge hclk);
    ev_req <= 4'h0;
    repeat (4) @(negedge hclk) seen = seen | {slp, stp, mv};
    chk("events", {29'h0, e}, {29'h0, seen});
  endtask
  task t_load_write;
    chk("node", 32'h65, {25'h0, node});
    chk("safe", 32'hE080, {16'h0, safe});
    chk("div", 32'h8, {27'h0, div});
    chk("thr", 32'h76C, {18'h0, thr});
    chk("en", 32'h1, {31'h0, sten});
    chk("uvw", 32'h170C, {18'h0, uvw});
    chk("rdy", 32'h1, {31'h0, prdy});
    nv[19:16] <= 4'hA;
    ahb(1'h1, 8'h00, 32'h001F_F0FF);
    ahb(1'h1, 8'h08, 32'h0);
    ahb(1'h0, 8'h08, 32'h0);
    chk("addr", 32'h65, {25'h0, rd[6:0]});
    chk("coil", 32'h320, {21'h0, coil});
    chk("keep", 32'h65, {25'h0, node});
    chk("vmax", 32'h3CD, {22'h0, vmax});
    chk("grp", 32'h3, {30'h0, grp});
    chk("acc", 32'h9C6F, {16'h0, acc});
    chk("shaft", 32'h1, {31'h0, shft});
    @(posedge hclk) boost <= 1'h1;
    repeat (3) @(negedge hclk);
    chk("boost", 32'h44C, {21'h0, coil});
    @(posedge hclk) boost <= 1'h0;
    $display("load and write done");
  endtask
  task t_hold;
    int i;
    @(posedge hclk) stopped <= 1'h1;
    for (i = 0; i < 20 && coil !== 11'h03B; i++) @(negedge hclk);
    chk("min", 32'h3B, {21'h0, coil});
    for (i = 0; i < 20 && gnd !== 1'h1; i++) @(negedge hclk);
    chk("pwm", 32'h0, {31'h0, pwm});
    @(negedge hclk);
    chk("zero", 32'h0, {21'h0, coil});
    @(posedge hclk) stopped <= 1'h0;
    ahb(1'h1, 8'h00, 32'h0000_003F);
    @(posedge hclk) stopped <= 1'h1;
    repeat (3) @(negedge hclk);
    chk("hold", 32'h64, {21'h0, coil});
    @(posedge hclk) stopped <= 1'h0;
    $display("hold done");
  endtask
  task t_events;
    ev_chk(4'h2, 3'h4);
    ev_chk(4'h1, 3'h4);
    ev_chk(4'h4, 3'h1);
    ahb(1'h1, 8'h04, 32'h0000_2300);
    repeat (2) @(negedge hclk);
    chk("div16", 32'h10, {27'h0, div});
    chk("off", 32'h0, {18'h0, thr});
    chk("en0", 32'h0, {31'h0, sten});
    ev_chk(4'h2, 3'h2);
    ev_chk(4'h1, 3'h3);
    @(posedge hclk) sby <= 1'h1;
    ev_chk(4'h1, 3'h5);
    @(posedge hclk) sby <= 1'h0;
    ahb(1'h1, 8'h00, 32'h8000_00FF);
    ev_chk(4'h8, 3'h0);
    chk("dual", 32'h0, {31'h0, dual});
    ev_chk(4'h4, 3'h1);
    ahb(1'h1, 8'h0C, 32'h5);
    ahb(1'h0, 8'h10, 32'h0);
    chk("nvbyte", 32'hE0, rd);
    $display("events done");
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (3) @(posedge hclk);
    t_load_write;
    t_hold;
    t_events;
    tally_and_finish;
  end
endmodule
